// >>> rtl/pmt_table_read.sv
/*
 * pmt_table_read: program store, fetch path and table-read unit of an 8-bit core.
 * assumes: the core pulses a table request at the first phase of an instruction,
 * keeps the pointers stable during it, and pin inputs are asynchronous.
 */
`timescale 1ns/1ps
module pmt_table_read
    import pmt_pkg::*;
#(
    parameter int DEPTH   = PMT_DEPTH_DEF,
    parameter int ADDR_W  = $clog2(DEPTH),
    parameter int HI_W    = 8
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // fetch side
    input  wire logic [ADDR_W-1:0]   pc,
    output logic      [PMT_WORD_W-1:0] instr_word,
    output logic      [1:0]          phase,
    output logic                     fetch_strobe,
    // table read request
    input  wire logic                tbl_req,
    input  wire logic                tbl_last_page,
    input  wire logic                tbl_extended,
    input  wire logic [PMT_SECTOR_W-1:0] tbl_dest_sector,
    input  wire logic [7:0]          tbl_dest_addr,
    input  wire logic [7:0]          tbl_ptr_lo,
    input  wire logic [7:0]          tbl_ptr_hi,
    output logic                     tbl_busy,
    output logic                     tbl_done,
    output logic                     tbl_illegal,
    output logic                     dmem_we,
    output logic      [PMT_SECTOR_W-1:0] dmem_sector,
    output logic      [7:0]          dmem_addr,
    output logic      [7:0]          dmem_wdata,
    // holding register access
    input  wire logic                hold_wr,
    input  wire logic [7:0]          hold_wdata,
    output logic      [7:0]          table_high_byte_holder,
    // programming and debug pins
    input  wire logic                prog_serial_clock_pin,
    input  wire logic                prog_serial_data_in,
    output logic                     prog_serial_data_out,
    output logic                     prog_serial_data_oe,
    input  wire logic                prog_load_en,
    input  wire logic [ADDR_W-1:0]   prog_load_addr,
    input  wire logic [PMT_WORD_W-1:0] prog_load_data,
    output logic                     prog_clk_rise,
    output logic                     prog_data_sync,
    input  wire logic                debug_drive,
    input  wire logic                debug_drive_bit
);
    initial begin
        if (DEPTH < PMT_DEPTH_MIN || DEPTH > PMT_DEPTH_MAX || (1 << ADDR_W) < DEPTH)
            $error("pmt_table_read: unsupported program store depth");
        if (HI_W < ADDR_W - 8 || HI_W > 8)
            $error("pmt_table_read: unsupported high pointer width");
    end

    pmt_phase_t phase_q;
    pmt_tbl_t   tbl_q;
    logic [ADDR_W-1:0]      rd_addr;
    logic [ADDR_W-1:0]      tbl_addr_q;
    logic [PMT_WORD_W-1:0]  rom_data;
    logic [7:0]             hold_q;
    logic [7:0]             dest_q;
    logic [PMT_SECTOR_W-1:0] sect_q;
    logic [2:0]             ck_sync_q;
    logic [1:0]             da_sync_q;
    logic                   ext_ok;
    logic [15:0]            tbl_full;

    // four phases per instruction cycle, restarting at the first after reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PMT_PH1;
        end else begin
            case (phase_q)
                PMT_PH1: phase_q <= PMT_PH2;
                PMT_PH2: phase_q <= PMT_PH3;
                PMT_PH3: phase_q <= PMT_PH4;
                PMT_PH4: phase_q <= PMT_PH1;
                default: phase_q <= PMT_PH1;
            endcase
        end
    end
    assign phase        = phase_q;
    assign fetch_strobe = (phase_q == PMT_PH1);

    assign tbl_full = {tbl_ptr_hi, tbl_ptr_lo};
    // extended form needed outside sector 0, basic form only inside it
    assign ext_ok = tbl_extended ? (tbl_dest_sector != PMT_SECTOR_BASE)
                                 : (tbl_dest_sector == PMT_SECTOR_BASE);

    // table state: cycle one addresses the store, cycle two delivers the bytes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tbl_q      <= PMT_TBL_IDLE;
            tbl_addr_q <= '0;
            dest_q     <= '0;
            sect_q     <= '0;
        end else begin
            case (tbl_q)
                PMT_TBL_IDLE: begin
                    if (tbl_req && fetch_strobe && ext_ok) begin
                        tbl_q      <= PMT_TBL_FIRST;
                        tbl_addr_q <= tbl_full[ADDR_W-1:0];
                        dest_q     <= tbl_dest_addr;
                        sect_q     <= tbl_dest_sector;
                    end
                end
                PMT_TBL_FIRST: begin
                    if (phase_q == PMT_PH4) begin
                        tbl_q <= PMT_TBL_SECOND;
                    end
                end
                PMT_TBL_SECOND: begin
                    if (phase_q == PMT_PH4) begin
                        tbl_q <= PMT_TBL_IDLE;
                    end
                end
                default: tbl_q <= PMT_TBL_IDLE;
            endcase
        end
    end
    assign tbl_busy    = (tbl_q != PMT_TBL_IDLE);
    assign tbl_illegal = tbl_req && fetch_strobe && !ext_ok && !tbl_busy;
    // the last-page variant differs only in how the core builds the pointer
    logic unused_last;
    assign unused_last = tbl_last_page;

    // fetch uses the program counter, reset value is the reset entry
    assign rd_addr = tbl_busy ? tbl_addr_q : pc;

    pmt_rom #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (PMT_WORD_W)
    ) u_rom (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .rd_addr (rd_addr),
        .rd_data (rom_data),
        .wr_en   (prog_load_en),
        .wr_addr (prog_load_addr),
        .wr_data (prog_load_data)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_word <= '0;
        end else if (phase_q == PMT_PH2 && !tbl_busy) begin
            instr_word <= rom_data;
        end
    end

    // low byte to data memory at the end of the second cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dmem_we    <= 1'b0;
            dmem_sector <= '0;
            dmem_addr  <= '0;
            dmem_wdata <= '0;
            tbl_done   <= 1'b0;
        end else begin
            dmem_we  <= (tbl_q == PMT_TBL_SECOND) && (phase_q == PMT_PH4);
            tbl_done <= (tbl_q == PMT_TBL_SECOND) && (phase_q == PMT_PH4);
            if ((tbl_q == PMT_TBL_SECOND) && (phase_q == PMT_PH4)) begin
                dmem_sector <= sect_q;
                dmem_addr   <= dest_q;
                dmem_wdata  <= rom_data[7:0];
            end
        end
    end

    // holding register: only a table read or software write changes it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= PMT_HOLD_RESET;
        end else if ((tbl_q == PMT_TBL_SECOND) && (phase_q == PMT_PH4)) begin
            hold_q <= rom_data[15:8];
        end else if (hold_wr) begin
            hold_q <= hold_wdata;
        end
    end
    assign table_high_byte_holder = hold_q;

    // shared serial pins; a tool drives the clock, data pin turns around
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_sync_q <= '0;
            da_sync_q <= '0;
        end else begin
            ck_sync_q <= {ck_sync_q[1:0], prog_serial_clock_pin};
            da_sync_q <= {da_sync_q[0], prog_serial_data_in};
        end
    end
    // edge detect reads only the second and third stages
    assign prog_clk_rise        = ck_sync_q[1] && !ck_sync_q[2];
    assign prog_data_sync       = da_sync_q[1];
    assign prog_serial_data_oe  = debug_drive;
    assign prog_serial_data_out = debug_drive_bit;

    a_reset_fetch: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> phase_q == PMT_PH1)
        else $error("fetch phase not at start after reset");
    a_tbl_two_cyc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tbl_q == PMT_TBL_IDLE && tbl_req && fetch_strobe && ext_ok)
        |=> tbl_busy [*7] ##1 (!tbl_busy && tbl_done))
        else $error("table read not two instruction cycles");
    a_low_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dmem_we |-> dmem_wdata == $past(rom_data[7:0]) && dmem_addr == dest_q)
        else $error("low byte not delivered");
    a_high_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tbl_done |-> hold_q == $past(rom_data[15:8]))
        else $error("high byte not held");
    a_hold_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(hold_wr) && !tbl_done |-> $stable(hold_q))
        else $error("holding register changed without cause");
    a_hold_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hold_wr && !((tbl_q == PMT_TBL_SECOND) && (phase_q == PMT_PH4))
        |=> hold_q == $past(hold_wdata))
        else $error("software write to holding register lost");
    a_tbl_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tbl_q == PMT_TBL_IDLE && tbl_req && fetch_strobe && ext_ok)
        |=> tbl_addr_q == $past(tbl_full[ADDR_W-1:0]))
        else $error("table address not from both pointers");
    a_sector_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tbl_extended && tbl_dest_sector == PMT_SECTOR_BASE && fetch_strobe && !tbl_busy
        |=> !tbl_busy)
        else $error("extended read accepted for sector 0");
    a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fetch_strobe |=> !fetch_strobe [*3] ##1 fetch_strobe)
        else $error("instruction cycle not four phases");

    c_basic_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
        tbl_done && dmem_sector == PMT_SECTOR_BASE);
    c_ext_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
        tbl_done && dmem_sector != PMT_SECTOR_BASE);
    c_hold_write: cover property (@(posedge ref_clk) disable iff (!rst_n) hold_wr);
    c_illegal: cover property (@(posedge ref_clk) disable iff (!rst_n) tbl_illegal);
endmodule

// >>> rtl/pmt_pkg.sv
/*
 * pmt_pkg: shared constants for the program memory table-read block.
 * assumes: a single 20 MHz system clock and an active-low asynchronous reset.
 */
package pmt_pkg;
    localparam int          PMT_WORD_W      = 16;
    localparam int          PMT_DEPTH_MIN   = 4096;
    localparam int          PMT_DEPTH_MAX   = 8192;
    localparam int          PMT_DEPTH_DEF   = 8192;
    localparam logic [12:0] PMT_RESET_ADDR  = 13'h0000;
    localparam int          PMT_PHASES      = 4;
    localparam int          PMT_TBL_CYCLES  = 2;
    localparam logic [7:0]  PMT_HOLD_RESET  = 8'h00;
    localparam int          PMT_SECTOR_W    = 3;
    localparam logic [2:0]  PMT_SECTOR_BASE = 3'h0;

    typedef enum logic [1:0] {
        PMT_PH1,
        PMT_PH2,
        PMT_PH3,
        PMT_PH4
    } pmt_phase_t;

    typedef enum logic [1:0] {
        PMT_TBL_IDLE,
        PMT_TBL_FIRST,
        PMT_TBL_SECOND
    } pmt_tbl_t;
endpackage

// >>> rtl/pmt_rom.sv
/*
 * pmt_rom: program word store with a registered read port and a load port.
 * assumes: the contents are loaded through the write port by the programming path.
 */
`timescale 1ns/1ps
module pmt_rom #(
    parameter int DEPTH  = 8192,
    parameter int ADDR_W = 13,
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // read port
    input  wire logic [ADDR_W-1:0]   rd_addr,
    output logic      [DATA_W-1:0]   rd_data,
    // load port
    input  wire logic                wr_en,
    input  wire logic [ADDR_W-1:0]   wr_addr,
    input  wire logic [DATA_W-1:0]   wr_data
);
    logic [DATA_W-1:0] mem_q [DEPTH];

    initial begin
        if (DEPTH < 1 || (1 << ADDR_W) < DEPTH)
            $error("pmt_rom: depth does not fit the address width");
    end

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

// >>> bench/pmt_cpu_model.sv
/*
 * pmt_cpu_model: core side of the table-read path, issuing table reads.
 * assumes: requests go out at the falling edge while fetch_strobe is high.
 */
`timescale 1ns/1ps
module pmt_cpu_model (
    // clock and status
    input  wire logic       ref_clk,
    input  wire logic       fetch_strobe,
    input  wire logic       tbl_done,
    input  wire logic       tbl_illegal,
    // request
    output logic            tbl_req,
    output logic            tbl_extended,
    output logic [2:0]      tbl_dest_sector,
    output logic [7:0]      tbl_dest_addr,
    output logic [7:0]      tbl_ptr_lo,
    output logic [7:0]      tbl_ptr_hi
);
    initial begin
        {tbl_req, tbl_extended, tbl_dest_sector, tbl_dest_addr} = '0;
        {tbl_ptr_lo, tbl_ptr_hi} = '0;
    end

    // one read at a time, so no second reader can clobber the holder
    task automatic rd(input logic ext, input logic [2:0] sec, input logic [7:0] dst,
                      input logic [7:0] lo, input logic [7:0] hi,
                      output logic ill, output int lat);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (fetch_strobe !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        // both pointer bytes set with the request, kept afterwards
        tbl_ptr_lo = lo;
        tbl_ptr_hi = hi;
        {tbl_extended, tbl_dest_sector, tbl_dest_addr} = {ext, sec, dst};
        tbl_req = 1'b1;
        #1 ill = tbl_illegal;
        @(negedge ref_clk);
        tbl_req = 1'b0;
        lat = 1;
        while (tbl_done !== 1'b1 && lat < 12) begin
            @(negedge ref_clk);
            lat++;
        end
    endtask
endmodule

// >>> bench/tb_pmt_table_read.sv
/*
 * tb_pmt_table_read: directed tests of fetch, table reads, holder and pins.
 * assumes: store depth 4096, so pointers are cut to 12 address bits.
 */
`timescale 1ns/1ps
module tb_pmt_table_read;
    import pmt_pkg::*;
    localparam int AW = 12;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [AW-1:0] pc = '0, prog_load_addr = '0;
    logic [15:0] instr_word, prog_load_data = '0;
    logic [1:0] phase;
    logic fetch_strobe, tbl_req, tbl_extended, tbl_busy, tbl_done, tbl_illegal;
    logic [2:0] tbl_dest_sector, dmem_sector;
    logic [7:0] tbl_dest_addr, tbl_ptr_lo, tbl_ptr_hi, dmem_addr, dmem_wdata;
    logic [7:0] hold_wdata = '0, table_high_byte_holder;
    logic dmem_we, hold_wr = 1'b0, prog_load_en = 1'b0, sclk = 1'b0, tool_bit = 1'b1;
    logic dout, doe, dbg_drv = 1'b0, dbg_bit = 1'b0, clk_rise, data_sync;
    wire  pin = doe ? dout : tool_bit;
    int error_cnt = 0, checks = 0, lat;
    logic ill;

    always #25 ref_clk = ~ref_clk;

    pmt_table_read #(.DEPTH(4096)) i_pmt_table_read (
        .ref_clk(ref_clk), .rst_n(rst_n), .pc(pc), .instr_word(instr_word),
        .phase(phase), .fetch_strobe(fetch_strobe), .tbl_req(tbl_req),
        .tbl_last_page(1'b0), .tbl_extended(tbl_extended),
        .tbl_dest_sector(tbl_dest_sector), .tbl_dest_addr(tbl_dest_addr),
        .tbl_ptr_lo(tbl_ptr_lo), .tbl_ptr_hi(tbl_ptr_hi), .tbl_busy(tbl_busy),
        .tbl_done(tbl_done), .tbl_illegal(tbl_illegal), .dmem_we(dmem_we),
        .dmem_sector(dmem_sector), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
        .hold_wr(hold_wr), .hold_wdata(hold_wdata),
        .table_high_byte_holder(table_high_byte_holder),
        .prog_serial_clock_pin(sclk), .prog_serial_data_in(pin),
        .prog_serial_data_out(dout), .prog_serial_data_oe(doe),
        .prog_load_en(prog_load_en), .prog_load_addr(prog_load_addr),
        .prog_load_data(prog_load_data), .prog_clk_rise(clk_rise),
        .prog_data_sync(data_sync), .debug_drive(dbg_drv), .debug_drive_bit(dbg_bit));

    pmt_cpu_model i_pmt_cpu_model (
        .ref_clk(ref_clk), .fetch_strobe(fetch_strobe), .tbl_done(tbl_done),
        .tbl_illegal(tbl_illegal), .tbl_req(tbl_req), .tbl_extended(tbl_extended),
        .tbl_dest_sector(tbl_dest_sector), .tbl_dest_addr(tbl_dest_addr),
        .tbl_ptr_lo(tbl_ptr_lo), .tbl_ptr_hi(tbl_ptr_hi));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic load(input logic [AW-1:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        {prog_load_en, prog_load_addr, prog_load_data} = {1'b1, a, d};
        @(negedge ref_clk);
        prog_load_en = 1'b0;
    endtask

    task automatic t_fetch;
        load(12'h000, 16'h5AC3);
        load(12'hF05, 16'h3C0F);
        load(12'hF06, 16'hA51A);
        repeat (8) @(negedge ref_clk);
        check("reset word", instr_word, 16'h5AC3);
        pc = 12'hF06;
        repeat (8) @(negedge ref_clk);
        check("fetch word", instr_word, 16'hA51A);
        $display("test fetch done");
    endtask

    task automatic t_table;
        // high pointer bits above the 12-bit store are dropped
        i_pmt_cpu_model.rd(1'b0, 3'h0, 8'h40, 8'h06, 8'h1F, ill, lat);
        check("latency", 16'(lat), 16'h0008);
        check("write strobe", {15'h0, dmem_we}, 16'h0001);
        check("idle at fetch", {12'h0, fetch_strobe, tbl_busy, phase}, 16'h0008);
        check("low byte", {8'h00, dmem_wdata}, 16'h001A);
        check("high byte", {8'h00, table_high_byte_holder}, 16'h00A5);
        check("dest", {5'h00, dmem_sector, dmem_addr}, 16'h0040);
        i_pmt_cpu_model.rd(1'b0, 3'h0, 8'h41, 8'h05, 8'h1F, ill, lat);
        check("back to back", 16'(lat), 16'h0008);
        check("word f05", {dmem_wdata, table_high_byte_holder}, 16'h0F3C);
        $display("test table done");
    endtask

    task automatic t_forms;
        i_pmt_cpu_model.rd(1'b1, 3'h5, 8'h22, 8'h00, 8'h00, ill, lat);
        check("ext legal", {15'h0, ill}, 16'h0000);
        check("ext done", 16'(lat), 16'h0008);
        check("ext dest", {5'h00, dmem_sector, dmem_addr}, 16'h0522);
        check("ext hi", {8'h00, table_high_byte_holder}, 16'h005A);
        i_pmt_cpu_model.rd(1'b0, 3'h5, 8'h23, 8'h06, 8'h0F, ill, lat);
        check("basic sector 5", {15'h0, ill}, 16'h0001);
        check("no done", 16'(lat), 16'h000C);
        i_pmt_cpu_model.rd(1'b1, 3'h0, 8'h23, 8'h06, 8'h0F, ill, lat);
        check("ext sector 0", {15'h0, ill}, 16'h0001);
        check("holder kept", {8'h00, table_high_byte_holder}, 16'h005A);
        $display("test forms done");
    endtask

    task automatic t_hold;
        @(negedge ref_clk);
        {hold_wr, hold_wdata} = {1'b1, 8'hC7};
        @(negedge ref_clk);
        hold_wr = 1'b0;
        check("holder write", {8'h00, table_high_byte_holder}, 16'h00C7);
        repeat (12) @(negedge ref_clk);
        check("holder steady", {8'h00, table_high_byte_holder}, 16'h00C7);
        $display("test holder done");
    endtask

    task automatic t_pins;
        int n;
        @(negedge ref_clk);
        {dbg_drv, dbg_bit} = 2'b11;
        #1 check("pin driven", {14'h0, doe, pin}, 16'h0003);
        @(negedge ref_clk);
        dbg_bit = 1'b0;
        #1 check("pin low", {14'h0, doe, pin}, 16'h0002);
        @(negedge ref_clk);
        dbg_drv = 1'b0;
        tool_bit = 1'b0;
        @(negedge ref_clk);
        // data bit moves with the tool clock; clock through three flops, data through two
        sclk = 1'b1;
        tool_bit = 1'b1;
        n = 0;
        while (clk_rise !== 1'b1 && n < 6) begin
            @(negedge ref_clk);
            n++;
        end
        check("clk seen", {15'h0, clk_rise}, 16'h0001);
        check("data in", {15'h0, data_sync}, 16'h0001);
        sclk = 1'b0;
        $display("test pins done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        t_fetch;
        t_table;
        t_forms;
        t_hold;
        t_pins;
        print_verdict;
    end

    // whole run is well under 300 cycles
    initial begin
        #(3000 * 50);
        error_cnt++;
        print_verdict;
    end
endmodule
